// File: include/mpr_pkg.sv
/*
 * Constants for the multifunction terminal routing block: register
 * indices, byte addresses, masks, reset values and select codes.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package mpr_pkg;

	// Register indices and APB byte addresses (index times four)
	localparam int          APB_AW      = 12;
	localparam logic [7:0]  GPO_IDX     = 8'h8b;
	localparam logic [7:0]  ROUTE_IDX   = 8'h8c;
	localparam logic [11:0] GPO_ADDR    = {2'h0, GPO_IDX, 2'h0};
	localparam logic [11:0] ROUTE_ADDR  = {2'h0, ROUTE_IDX, 2'h0};

	// Reset values and writable masks
	localparam logic [7:0]  GPO_RST     = 8'h00;
	localparam logic [7:0]  GPO_WMASK   = 8'h1f;
	localparam logic [31:0] ROUTE_RST   = 32'h00001000;
	localparam logic [31:0] ROUTE_WMASK = 32'h0fffffff;

	// Terminal and field layout
	localparam int TERM_COUNT = 7;
	localparam int GPO_COUNT  = 5;
	localparam int FIELD_W    = 4;
	localparam int T6_LSB     = 24;
	localparam int T5_LSB     = 20;
	localparam int T3_LSB     = 12;
	localparam int T1_LSB     = 4;
	localparam int T0_LSB     = 0;

	// Select codes used by the terminal decoders
	localparam logic [3:0] SEL_C0  = 4'h0;
	localparam logic [3:0] SEL_C1  = 4'h1;
	localparam logic [3:0] SEL_C2  = 4'h2;
	localparam logic [3:0] SEL_C3  = 4'h3;
	localparam logic [3:0] SEL_C4  = 4'h4;
	localparam logic [3:0] SEL_C5  = 4'h5;
	localparam logic [3:0] SEL_C6  = 4'h6;
	localparam logic [3:0] SEL_C7  = 4'h7;
	localparam logic [3:0] SEL_C8  = 4'h8;
	localparam logic [3:0] SEL_C9  = 4'h9;
	localparam logic [3:0] SEL_CA  = 4'ha;
	localparam logic [3:0] SEL_CB  = 4'hb;
	localparam logic [3:0] SEL_CC  = 4'hc;
	localparam logic [3:0] SEL_CD  = 4'hd;
	localparam logic [3:0] SEL_CE  = 4'he;
	localparam logic [3:0] SEL_CF  = 4'hf;

endpackage

// File: include/mpr_src_if.sv
/*
 * Bundle of internal function levels that the terminal decoders may
 * route out. Assumes all sources are on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface mpr_src_if;
	logic [15:0] irq_line;
	logic [4:0]  out_level;
	logic        clock_run_request;
	logic        serialized_interrupt;
	logic        card_bus_grant;
	logic        video_port_status;
	logic        video_select_zero;
	logic        card_audio_output;
	logic        link_activity_lamp;
	logic        socket_activity_lamp;
	logic        wake_event_output;
	logic        pci_int_b;

	modport src (
		output irq_line, out_level, clock_run_request, serialized_interrupt,
		card_bus_grant, video_port_status, video_select_zero, card_audio_output,
		link_activity_lamp, socket_activity_lamp, wake_event_output, pci_int_b
	);
	modport dec (
		input irq_line, out_level, clock_run_request, serialized_interrupt,
		card_bus_grant, video_port_status, video_select_zero, card_audio_output,
		link_activity_lamp, socket_activity_lamp, wake_event_output, pci_int_b
	);
endinterface

`default_nettype wire

// File: core/mpr_term_dec.sv
/*
 * Decoder for one shared terminal: turns its 4-bit select code into a
 * drive level and an enable. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
`default_nettype none

module mpr_term_dec
	import mpr_pkg::*;
#(
	parameter int TERM = 0
) (
	// Select and sources
	input  wire logic [3:0] sel,
	mpr_src_if.dec          src,
	// Terminal drive
	output logic            drv,
	output logic            oe
);

	// Code table per terminal; unlisted or reserved codes leave it undriven
	always_comb begin
		drv = 1'b0;
		oe  = 1'b0;
		case (TERM)
			6: begin
				if (sel == SEL_C1) begin
					drv = src.clock_run_request;
					oe  = 1'b1;
				end else if (sel != SEL_C0) begin
					drv = src.irq_line[sel];
					oe  = 1'b1;
				end
			end
			3: begin
				if (sel == SEL_C1) begin
					drv = src.serialized_interrupt;
					oe  = 1'b1;
				end else if (sel != SEL_C0) begin
					drv = src.irq_line[sel];
					oe  = 1'b1;
				end
			end
			5: begin
				oe = 1'b1;
				case (sel)
					SEL_C0: oe = 1'b0;
					SEL_C1: drv = src.out_level[4];
					SEL_C2: drv = src.card_bus_grant;
					SEL_C3, SEL_C4, SEL_C5: drv = src.irq_line[sel];
					SEL_C6: drv = src.video_port_status;
					SEL_C8: drv = src.card_audio_output;
					SEL_C9, SEL_CA, SEL_CF: drv = src.irq_line[sel];
					SEL_CB: drv = src.link_activity_lamp;
					SEL_CC, SEL_CD: drv = src.socket_activity_lamp;
					SEL_CE: drv = src.wake_event_output;
					default: oe = 1'b0;
				endcase
			end
			1: begin
				oe = 1'b1;
				case (sel)
					SEL_C1: drv = src.out_level[1];
					SEL_C2: drv = src.pci_int_b;
					SEL_C4: drv = src.link_activity_lamp;
					SEL_C5, SEL_CF: drv = src.irq_line[sel];
					SEL_CC: drv = src.socket_activity_lamp;
					SEL_CE: drv = src.wake_event_output;
					default: oe = 1'b0;
				endcase
			end
			0: begin
				oe = 1'b1;
				case (sel)
					SEL_C1: drv = src.out_level[0];
					SEL_C4, SEL_C5, SEL_CF: drv = src.irq_line[sel];
					SEL_C6: drv = src.video_port_status;
					SEL_C7: drv = src.video_select_zero;
					SEL_CC: drv = src.socket_activity_lamp;
					SEL_CE: drv = src.wake_event_output;
					default: oe = 1'b0;
				endcase
			end
			// Terminals 4 and 2 keep their field but drive nothing yet
			default: begin
				drv = 1'b0;
				oe  = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// File: core/mpr_top.sv
/*
 * Multifunction terminal routing: APB registers for output levels and
 * terminal routing, serial-ROM preset, per-terminal decoders, pin sync.
 * Assumes APB master and sources on core_clk; terminals are board pins.
 */
// Our own choice: the APB slave port.
// Functional notes
// - Output register bits 0..4 set the matching general output level and read back.
// - Output register bits 7..5 read as zero and ignore writes.
// - Routing register bits 31..28 always read as zero.
// - Terminal 6 code 0 is reserved, 1 is clock-run, 2..15 are interrupt lines 2..15.
// - Terminal 5 codes 0..7 give input 4, output 4, grant, irq 3..5, video status, reserved.
// - Terminal 5 codes 8..15 give audio, irq 9/10, link lamp, socket lamp, wake, irq 15.
// - Terminal 3 code 0 is reserved, 1 is serial interrupt, 2..15 are interrupt lines.
// - Terminal 1 maps output 1, int B, link lamp, irq 5, socket lamp, wake, irq 15.
// - Terminal 0 maps output 0, irq 4/5, video status, video select, lamp, wake, irq 15.
// - Only the global reset returns the routing register to its default.
// - A serial ROM value may replace the routing register contents at start.
// - With terminal 5 as input 4, any level change raises an event pulse.
`timescale 1ns/1ps
`default_nettype none

module mpr_top
	import mpr_pkg::*;
(
	// Clock and resets
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              global_reset_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Serial ROM preset
	input  wire logic              rom_load_valid,
	input  wire logic [31:0]       rom_load_data,
	// Internal function sources
	input  wire logic [15:0]       irq_line,
	input  wire logic              clock_run_request,
	input  wire logic              serialized_interrupt,
	input  wire logic              card_bus_grant,
	input  wire logic              video_port_status,
	input  wire logic              video_select_zero,
	input  wire logic              card_audio_output,
	input  wire logic              link_activity_lamp,
	input  wire logic              socket_activity_lamp,
	input  wire logic              wake_event_output,
	input  wire logic              pci_int_b,
	// Shared terminals
	input  wire logic [6:0]        term_in,
	output logic [6:0]             term_out,
	output logic [6:0]             term_oe,
	// Status toward the rest of the device
	output logic [4:0]             out_level,
	output logic                   general_input_four,
	output logic                   in4_change
);

	logic [7:0]  gpo_reg,      gpo_next;
	logic [31:0] route_reg,    route_next;
	logic [31:0] prdata_reg,   prdata_next;
	logic        pready_reg,   pready_next;
	logic        pslverr_reg,  pslverr_next;
	logic [6:0]  sync1_reg,    sync2_reg;
	logic        prev4_reg,    prev4_next;
	logic        chg_reg,      chg_next;
	logic [6:0]  tout_reg,     tout_next;
	logic [6:0]  toe_reg,      toe_next;
	logic        setup;
	logic        wr_en;
	logic        mapped;
	logic [31:0] wmask;

	mpr_src_if src_bus ();

	// Sources onto the decoder bundle
	assign src_bus.irq_line             = irq_line;
	assign src_bus.out_level            = gpo_reg[4:0];
	assign src_bus.clock_run_request    = clock_run_request;
	assign src_bus.serialized_interrupt = serialized_interrupt;
	assign src_bus.card_bus_grant       = card_bus_grant;
	assign src_bus.video_port_status    = video_port_status;
	assign src_bus.video_select_zero    = video_select_zero;
	assign src_bus.card_audio_output    = card_audio_output;
	assign src_bus.link_activity_lamp   = link_activity_lamp;
	assign src_bus.socket_activity_lamp = socket_activity_lamp;
	assign src_bus.wake_event_output    = wake_event_output;
	assign src_bus.pci_int_b            = pci_int_b;

	// APB phase decode; answer comes in the first access cycle
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pready_reg && pwrite;
	assign mapped = (paddr == GPO_ADDR) || (paddr == ROUTE_ADDR);
	assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Output level register and bus answer
	always_comb begin
		gpo_next     = gpo_reg;
		pready_next  = setup;
		pslverr_next = setup && !mapped;
		prdata_next  = 32'h00000000;
		if (wr_en && paddr == GPO_ADDR) begin
			gpo_next = ((gpo_reg & ~wmask[7:0]) | (pwdata[7:0] & wmask[7:0]))
				& GPO_WMASK;
		end
		if (setup && !pwrite) begin
			if (paddr == GPO_ADDR) begin
				prdata_next = {24'h000000, gpo_reg & GPO_WMASK};
			end else if (paddr == ROUTE_ADDR) begin
				prdata_next = route_reg & ROUTE_WMASK;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gpo_reg     <= GPO_RST;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			gpo_reg     <= gpo_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	// Routing register: ROM preset wins over a bus write in the same cycle
	always_comb begin
		route_next = route_reg;
		if (rom_load_valid) begin
			route_next = rom_load_data & ROUTE_WMASK;
		end else if (wr_en && paddr == ROUTE_ADDR) begin
			route_next = ((route_reg & ~wmask) | (pwdata & wmask))
				& ROUTE_WMASK;
		end
	end

	// Only the global reset touches the routing
	always_ff @(posedge core_clk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			route_reg <= ROUTE_RST;
		end else begin
			route_reg <= route_next;
		end
	end

	// Two-flop synchronisers for the terminal inputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else begin
			sync1_reg <= term_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Per-terminal decoders
	generate
		for (genvar t = 0; t < TERM_COUNT; t++) begin : g_term
			mpr_term_dec #(
				.TERM (t)
			) mpr_term_dec_inst (
				.sel  (route_reg[t*FIELD_W +: FIELD_W]),
				.src  (src_bus),
				.drv  (tout_next[t]),
				.oe   (toe_next[t])
			);
		end
	endgenerate

	// Input-4 change detect, only while terminal 5 is an input
	always_comb begin
		prev4_next = sync2_reg[5];
		chg_next   = (route_reg[T5_LSB +: FIELD_W] == SEL_C0)
			&& (sync2_reg[5] != prev4_reg);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev4_reg <= 1'b0;
			chg_reg   <= 1'b0;
			tout_reg  <= 7'h00;
			toe_reg   <= 7'h00;
		end else begin
			prev4_reg <= prev4_next;
			chg_reg   <= chg_next;
			tout_reg  <= tout_next;
			toe_reg   <= toe_next;
		end
	end

	// Outputs straight from flops
	assign prdata             = prdata_reg;
	assign pready             = pready_reg;
	assign pslverr            = pslverr_reg;
	assign term_out           = tout_reg;
	assign term_oe            = toe_reg;
	assign out_level          = gpo_reg[4:0];
	assign general_input_four = prev4_reg;
	assign in4_change         = chg_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_wr_gpo;
		psel && penable && pready && pwrite && paddr == GPO_ADDR && pstrb[0];
	endsequence

	sequence s_rd_gpo;
		setup && !pwrite && paddr == GPO_ADDR;
	endsequence

	sequence s_in4_toggle;
		route_reg[T5_LSB +: FIELD_W] == SEL_C0 ##1 $changed(prev4_reg);
	endsequence

	property p_gpo_write;
		s_wr_gpo |=> out_level == $past(pwdata[4:0]);
	endproperty
	a_gpo_write: assert property (p_gpo_write) else $error("level write lost");

	property p_gpo_read;
		s_rd_gpo |=> pready && prdata[31:5] == 27'h0 && prdata[4:0] == $past(out_level);
	endproperty
	a_gpo_read: assert property (p_gpo_read) else $error("level readback bad");

	property p_route_rsvd;
		pready && !pslverr |-> prdata[31:28] == 4'h0;
	endproperty
	a_route_rsvd: assert property (p_route_rsvd) else $error("reserved bits set");

	property p_t6_irq;
		route_reg[T6_LSB +: FIELD_W] > SEL_C1 && $stable(route_reg)
			|=> term_oe[6] && term_out[6] == $past(irq_line[route_reg[T6_LSB +: FIELD_W]]);
	endproperty
	a_t6_irq: assert property (p_t6_irq) else $error("terminal 6 irq wrong");

	property p_t5_gpo;
		route_reg[T5_LSB +: FIELD_W] == SEL_C1 |=> term_oe[5] && term_out[5] == $past(gpo_reg[4]);
	endproperty
	a_t5_gpo: assert property (p_t5_gpo) else $error("terminal 5 output wrong");

	property p_t5_wake;
		route_reg[T5_LSB +: FIELD_W] == SEL_CE |=> term_oe[5]
			&& term_out[5] == $past(wake_event_output);
	endproperty
	a_t5_wake: assert property (p_t5_wake) else $error("terminal 5 wake wrong");

	property p_t3_ser;
		route_reg[T3_LSB +: FIELD_W] == SEL_C1 |=> term_oe[3]
			&& term_out[3] == $past(serialized_interrupt);
	endproperty
	a_t3_ser: assert property (p_t3_ser) else $error("terminal 3 serial irq wrong");

	property p_t1_intb;
		route_reg[T1_LSB +: FIELD_W] == SEL_C2 |=> term_oe[1] && term_out[1] == $past(pci_int_b);
	endproperty
	a_t1_intb: assert property (p_t1_intb) else $error("terminal 1 int B wrong");

	property p_t0_vsel;
		route_reg[T0_LSB +: FIELD_W] == SEL_C7 |=> term_oe[0]
			&& term_out[0] == $past(video_select_zero);
	endproperty
	a_t0_vsel: assert property (p_t0_vsel) else $error("terminal 0 video select wrong");

	property p_keep_route;
		@(posedge core_clk) disable iff (!global_reset_n)
			!arst_n && !rom_load_valid |=> $stable(route_reg);
	endproperty
	a_keep_route: assert property (p_keep_route) else $error("routing lost on reset");

	property p_rom_load;
		@(posedge core_clk) disable iff (!global_reset_n)
			rom_load_valid |=> route_reg == ($past(rom_load_data) & ROUTE_WMASK);
	endproperty
	a_rom_load: assert property (p_rom_load) else $error("rom preset not taken");

	property p_in4_event;
		s_in4_toggle |-> in4_change;
	endproperty
	a_in4_event: assert property (p_in4_event) else $error("input 4 change missed");

	property p_rsvd_undriven;
		route_reg[T6_LSB +: FIELD_W] == SEL_C0 ##1 route_reg[T6_LSB +: FIELD_W] == SEL_C0
			|-> !term_oe[6];
	endproperty
	a_rsvd_undriven: assert property (p_rsvd_undriven) else $error("reserved driven");

	// Terminal 5 reserved code must release the pin
	property p_t5_rsvd;
		route_reg[T5_LSB +: FIELD_W] == SEL_C7 |=> !term_oe[5];
	endproperty
	a_t5_rsvd: assert property (p_t5_rsvd) else $error("terminal 5 reserved driven");

	// Terminal 3 interrupt codes follow the selected line
	property p_t3_irq;
		route_reg[T3_LSB +: FIELD_W] > SEL_C1 |=> term_oe[3]
			&& term_out[3] == $past(irq_line[route_reg[T3_LSB +: FIELD_W]]);
	endproperty
	a_t3_irq: assert property (p_t3_irq) else $error("terminal 3 irq wrong");

endmodule

`default_nettype wire

// File: verification/mpr_board.sv
/*
 * Board model on the seven shared terminals: resolves each wire level.
 * Assumes term_oe high means the routing block drives the terminal.
 */
`timescale 1ns/1ps
`default_nettype none

module mpr_board (
	// Clock
	input  wire logic       core_clk,
	// Block drive
	input  wire logic [6:0] term_out,
	input  wire logic [6:0] term_oe,
	// Board level offered on terminal 5
	input  wire logic       ext5,
	// Resolved wire levels
	output logic [6:0]      pin_level
);
	logic flip = 1'b0;

	// Floating pins wander every cycle so no stale level passes
	always_ff @(posedge core_clk) begin
		flip <= ~flip;
	end

	// Block drive wins; terminal 5 is driven by the board when released
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (term_oe[i])
				pin_level[i] = term_out[i];
			else if (i == 5)
				pin_level[i] = ext5;
			else
				pin_level[i] = flip ^ i[0];
		end
	end
endmodule

`default_nettype wire

// File: verification/mpr_top_test.sv
/*
 * Self-checking bench for the terminal routing block over APB.
 * Assumes no APB wait states are relied on; every wait is bounded.
 */
`timescale 1ns/1ps
`default_nettype none

module mpr_top_test
	import mpr_pkg::*;
;
	localparam logic [30:0] PAT = 31'h5a3c_96a5;
	localparam int T5[16] = '{-1, 30, 18, 3, 4, 5, 19, -1, 21, 9, 10, 22, 23, 23, 24, 15};
	localparam int T1[16] = '{-1, 27, 25, -1, 22, 5, -1, -1, -1, -1, -1, -1, 23, -1, 24, 15};
	localparam int T0[16] = '{-1, 26, -1, -1, 4, 5, 19, 20, -1, -1, -1, -1, 23, -1, 24, 15};

	logic core_clk = 1'b0, arst_n = 1'b0, global_reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rom_load_valid = 1'b0, ext5 = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rom_load_data = 32'h0, prdata, rdat, tgot, texp;
	logic [3:0]  pstrb = 4'hf;
	logic [25:0] src = 26'h0;
	logic [30:0] pat;
	logic [6:0]  term_in, term_out, term_oe;
	logic [4:0]  out_level;
	logic        pready, pslverr, rerr, general_input_four, in4_change;
	int          error_cnt = 0, n_tests = 0, chg_cnt = 0, n0, idx;

	// Clock at 200 MHz
	always #2.5 core_clk = ~core_clk;

	// Count input-four change pulses
	always @(posedge core_clk) begin
		if (in4_change === 1'b1)
			chg_cnt <= chg_cnt + 1;
	end

	mpr_top mpr_top_inst (
		.core_clk(core_clk), .arst_n(arst_n), .global_reset_n(global_reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rom_load_valid(rom_load_valid), .rom_load_data(rom_load_data),
		.irq_line(src[15:0]), .clock_run_request(src[16]), .serialized_interrupt(src[17]),
		.card_bus_grant(src[18]), .video_port_status(src[19]),
		.video_select_zero(src[20]), .card_audio_output(src[21]),
		.link_activity_lamp(src[22]), .socket_activity_lamp(src[23]),
		.wake_event_output(src[24]), .pci_int_b(src[25]), .term_in(term_in),
		.term_out(term_out), .term_oe(term_oe), .out_level(out_level),
		.general_input_four(general_input_four), .in4_change(in4_change)
	);

	mpr_board mpr_board_inst (
		.core_clk(core_clk), .term_out(term_out), .term_oe(term_oe),
		.ext5(ext5), .pin_level(term_in)
	);

	task automatic wrap_up();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// One APB transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			wrap_up();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
		xfer(1'b0, a, 32'h0);
		chk(rdat, exp);
		chk({31'h0, rerr}, {31'h0, err});
	endtask

	// Source index routed to terminal t by code c, -1 when undriven
	function automatic int exp_idx(input int t, input int c);
		case (t)
			6: return c == 0 ? -1 : (c == 1 ? 16 : c);
			3: return c == 0 ? -1 : (c == 1 ? 17 : c);
			5: return T5[c];
			1: return T1[c];
			0: return T0[c];
			default: return -1;
		endcase
	endfunction

	initial begin
		repeat (6) @(posedge core_clk);
		arst_n         <= 1'b1;
		global_reset_n <= 1'b1;
		@(posedge core_clk);
		// Reset values, masks and unmapped access
		rchk(GPO_ADDR, 32'h0, 1'b0);
		rchk(ROUTE_ADDR, 32'h0000_1000, 1'b0);
		xfer(1'b1, GPO_ADDR, 32'hffff_ffff);
		rchk(GPO_ADDR, 32'h0000_001f, 1'b0);
		chk({27'h0, out_level}, 32'h1f);
		xfer(1'b1, ROUTE_ADDR, 32'hffff_ffff);
		rchk(ROUTE_ADDR, 32'h0fff_ffff, 1'b0);
		// Byte-lane write clears only the terminal 3 and 2 fields
		pstrb <= 4'h2;
		xfer(1'b1, ROUTE_ADDR, 32'h0);
		rchk(ROUTE_ADDR, 32'h0fff_00ff, 1'b0);
		pstrb <= 4'hf;
		rchk(12'h000, 32'h0, 1'b1);
		// Device reset keeps routing; only global reset restores it
		xfer(1'b1, ROUTE_ADDR, 32'h0123_4567);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rchk(ROUTE_ADDR, 32'h0123_4567, 1'b0);
		rchk(GPO_ADDR, 32'h0, 1'b0);
		global_reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		global_reset_n <= 1'b1;
		@(posedge core_clk);
		rchk(ROUTE_ADDR, 32'h0000_1000, 1'b0);
		// Terminal 5 as input four, then reserved
		n0 = chg_cnt;
		ext5 <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		chk(chg_cnt - n0, 32'd1);
		chk({31'h0, general_input_four}, 32'h1);
		@(posedge core_clk);
		xfer(1'b1, ROUTE_ADDR, 32'h0070_1000);
		n0 = chg_cnt;
		ext5 <= 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		chk(chg_cnt - n0, 32'd0);
		@(posedge core_clk);
		// Serial ROM preset
		rom_load_valid <= 1'b1;
		rom_load_data  <= 32'hffff_ffff;
		@(posedge core_clk);
		rom_load_valid <= 1'b0;
		@(posedge core_clk);
		rchk(ROUTE_ADDR, 32'h0fff_ffff, 1'b0);
		// Every code on every terminal, with a pattern and its inverse
		for (int p = 0; p < 2; p++) begin
			pat = p ? ~PAT : PAT;
			src <= pat[25:0];
			xfer(1'b1, GPO_ADDR, {27'h0, pat[30:26]});
			for (int c = 0; c < 16; c++) begin
				xfer(1'b1, ROUTE_ADDR, {4'h0, {7{c[3:0]}}});
				repeat (2) @(posedge core_clk);
				#1;
				for (int t = 0; t < 7; t++) begin
					idx = exp_idx(t, c);
					tgot = {30'h0, term_oe[t], term_oe[t] & term_out[t]};
					texp = {30'h0, idx >= 0, idx >= 0 && pat[idx]};
					chk(tgot, texp);
				end
				@(posedge core_clk);
			end
		end
		wrap_up();
	end
endmodule

`default_nettype wire
